// File: hdl/rfi_frame_info.sv
// receive frame information register bank with wishbone slave
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module rfi_frame_info
  import rfi_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      arst_n,
  // wishbone classic slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [rfi_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [rfi_pkg::SEL_W-1:0]  wb_sel_i,
  input  wire logic [rfi_pkg::DATA_W-1:0] wb_dat_i,
  output logic [rfi_pkg::DATA_W-1:0]      wb_dat_o,
  output logic                           wb_ack_o,
  // header decoder, same clock
  input  wire logic                      headerDetected,
  input  wire logic [1:0]                hdrBitRate,
  input  wire logic                      hdrRanging,
  input  wire logic [1:0]                hdrPreambleRepetition,
  input  wire logic [rfi_pkg::ACC_W-1:0]  preambleAccumCount,
  input  wire logic [1:0]                receiverPulseRateSetting,
  // status and transmit settings
  output logic                           headerDetectedFlag,
  output logic [1:0]                     txLengthExtension,
  output logic [1:0]                     txPreambleRepetition
);

  typedef struct packed {
    logic                   wbAck;
    logic [DATA_W-1:0]      wbDat;
    logic [DATA_W-1:0]      info;
    logic                   hdrFlag;
    logic                   overrun;
    logic [FRAME_CNT_W-1:0] frameCnt;
    logic                   captEn;
    logic [1:0]             txExt;
    logic [1:0]             txRep;
  } rfi_state_t;

  localparam rfi_state_t RST_STATE = '{
    wbAck:    1'b0,
    wbDat:    '0,
    info:     RST_INFO,
    hdrFlag:  1'b0,
    overrun:  1'b0,
    frameCnt: '0,
    captEn:   RST_CAPT_EN,
    txExt:    RST_TX_EXT,
    txRep:    RST_TX_REP
  };

  logic              rstMeta;
  logic              rstSync;
  rfi_state_t        state_r;
  rfi_state_t        state_nxt;
  logic [1:0]        estRepetition;
  logic [1:0]        estNonstdLength;
  logic              busReq;
  logic              busWrite;
  logic              byte0Wr;
  logic [DATA_W-1:0] statusWord;
  logic [DATA_W-1:0] ctrlWord;
  logic [DATA_W-1:0] txcfgWord;
  logic [DATA_W-1:0] readWord;
  logic [DATA_W-1:0] captureWord;
  logic              clearHdr;
  logic              clearOverrun;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  rfi_length_estimate u_estimate (
    .hdrRepetition    (hdrPreambleRepetition),
    .accumCount       (preambleAccumCount),
    .repetitionCode   (estRepetition),
    .nonstdLengthCode (estNonstdLength)
  );

  // word captured at a good header
  always_comb
  begin
    captureWord                           = '0;
    captureWord[POS_ACC +: ACC_W]         = preambleAccumCount;       // see (R9)
    captureWord[POS_REP +: 2]             = estRepetition;            // see (R5)
    captureWord[POS_PRF +: 2]             = receiverPulseRateSetting; // see (R4)
    captureWord[POS_RNG]                  = hdrRanging;               // see (R3)
    captureWord[POS_BR +: 2]              = hdrBitRate;               // see (R2)
    captureWord[POS_NSL +: 2]             = estNonstdLength;          // see (R7)
  end

  // readable views of the software registers
  always_comb
  begin
    statusWord                              = '0;
    statusWord[POS_HDR_FLAG]                = state_r.hdrFlag;
    statusWord[POS_OVERRUN]                 = state_r.overrun;
    statusWord[POS_FRAME_CNT +: FRAME_CNT_W] = state_r.frameCnt;
    ctrlWord                                = '0;
    ctrlWord[POS_CAPT_EN]                   = state_r.captEn;
    txcfgWord                               = '0;
    txcfgWord[POS_TX_EXT +: 2]              = state_r.txExt;
    txcfgWord[POS_TX_REP +: 2]              = state_r.txRep;
  end

  // address decode, unmapped reads return zero
  always_comb
  begin
    case (wb_adr_i)
      OFS_INFO:   readWord = state_r.info;
      OFS_STATUS: readWord = statusWord;
      OFS_CTRL:   readWord = ctrlWord;
      OFS_TXCFG:  readWord = txcfgWord;
      default:    readWord = '0;
    endcase
  end

  // one access per request, ack for a single cycle
  assign busReq       = wb_cyc_i & wb_stb_i & ~state_r.wbAck;
  assign busWrite     = busReq & wb_we_i;
  assign byte0Wr      = busWrite & wb_sel_i[0];
  assign clearHdr     = byte0Wr & (wb_adr_i == OFS_STATUS) & wb_dat_i[POS_HDR_FLAG];
  assign clearOverrun = byte0Wr & (wb_adr_i == OFS_STATUS) & wb_dat_i[POS_OVERRUN];

  always_comb
  begin
    state_nxt       = state_r;
    state_nxt.wbAck = busReq;
    state_nxt.wbDat = (busReq & ~wb_we_i) ? readWord : '0;

    // capture only on a good header; info has no write path
    if (headerDetected && state_r.captEn)                   // see (R1)
    begin
      state_nxt.info = captureWord;                         // see (R10)
    end

    // software-side fields, set by hardware wins over the clear
    if (clearHdr)
      state_nxt.hdrFlag = 1'b0;
    if (clearOverrun)
      state_nxt.overrun = 1'b0;
    if (headerDetected)
    begin
      state_nxt.hdrFlag  = 1'b1;
      state_nxt.frameCnt = state_r.frameCnt + 1'b1;
      if (state_r.hdrFlag && !clearHdr)
        state_nxt.overrun = 1'b1;
    end

    if (byte0Wr && (wb_adr_i == OFS_CTRL))
      state_nxt.captEn = wb_dat_i[POS_CAPT_EN];

    // reply preamble settings written by software from the report
    if (byte0Wr && (wb_adr_i == OFS_TXCFG))                 // see (R8)
    begin
      state_nxt.txExt = wb_dat_i[POS_TX_EXT +: 2];
      state_nxt.txRep = wb_dat_i[POS_TX_REP +: 2];
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync)
  begin
    if (!rstSync)
      state_r <= RST_STATE;
    else
      state_r <= state_nxt;
  end

  assign wb_ack_o             = state_r.wbAck;
  assign wb_dat_o             = state_r.wbDat;
  assign headerDetectedFlag   = state_r.hdrFlag;
  assign txLengthExtension    = state_r.txExt;
  assign txPreambleRepetition = state_r.txRep;

endmodule

// File: hdl/rfi_pkg.sv
// constants for the receive frame information report
// What this block does
// (R1) Every reported field is captured only in the cycle the decoder signals a good header.
// (R2) Bits 14..13 give the received bit rate: 00 is 110 kbps, 01 is 850 kbps, 10 is 6.8 Mbps.
// (R3) Bit 15 gives the ranging bit carried in the received header.
// (R4) Bits 17..16 are a copy of the receiver pulse rate setting, 01 for 16 MHz and 10 for 64 MHz.
// (R5) Bits 19..18 give the preamble repetition: 00 is 16, 01 is 64, 10 is 1024, 11 is 4096 symbols.
// (R6) Non-standard preamble lengths are estimated from the header repetition code and the accumulation count.
// (R7) Bits 19..18 with bits 12..11 encode 64, 128, 256, 512, 1024, 1536 and 2048 symbols.
// (R8) Software may reuse the reported length and repetition codes as the reply's transmit settings.
// (R9) Bits 31..20 hold the count of preamble symbols accumulated during reception.
// (R10) The reported fields are read-only; writes leave the captured values untouched.
package rfi_pkg;

  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          SEL_W          = 4;
  localparam int          ACC_W          = 12;

  // register byte addresses
  localparam logic [7:0]  OFS_INFO       = 8'h10;
  localparam logic [7:0]  OFS_STATUS     = 8'h14;
  localparam logic [7:0]  OFS_CTRL       = 8'h18;
  localparam logic [7:0]  OFS_TXCFG      = 8'h1c;

  // rx_frame_information layout
  localparam int          POS_ACC        = 20;
  localparam int          POS_REP        = 18;
  localparam int          POS_PRF        = 16;
  localparam int          POS_RNG        = 15;
  localparam int          POS_BR         = 13;
  localparam int          POS_NSL        = 11;

  // status layout
  localparam int          POS_HDR_FLAG   = 0;
  localparam int          POS_OVERRUN    = 1;
  localparam int          POS_FRAME_CNT  = 16;
  localparam int          FRAME_CNT_W    = 16;

  // control and transmit configuration layout
  localparam int          POS_CAPT_EN    = 0;
  localparam int          POS_TX_EXT     = 0;
  localparam int          POS_TX_REP     = 2;

  // reset values
  localparam logic [31:0] RST_INFO       = 32'h0000_0000;
  localparam logic        RST_CAPT_EN    = 1'b1;
  localparam logic [1:0]  RST_TX_EXT     = 2'h0;
  localparam logic [1:0]  RST_TX_REP     = 2'h1;

  // encodings
  localparam logic [1:0]  BR_110K        = 2'h0;
  localparam logic [1:0]  BR_850K        = 2'h1;
  localparam logic [1:0]  BR_6M8         = 2'h2;
  localparam logic [1:0]  PRF_16M        = 2'h1;
  localparam logic [1:0]  PRF_64M        = 2'h2;
  localparam logic [1:0]  REP_16         = 2'h0;
  localparam logic [1:0]  REP_64         = 2'h1;
  localparam logic [1:0]  REP_1024       = 2'h2;
  localparam logic [1:0]  REP_4096       = 2'h3;
  localparam logic [1:0]  NSL_BASE       = 2'h0;
  localparam logic [1:0]  NSL_STEP1      = 2'h1;
  localparam logic [1:0]  NSL_STEP2      = 2'h2;
  localparam logic [1:0]  NSL_STEP3      = 2'h3;

  // count thresholds between neighbouring lengths (midpoints)
  localparam logic [11:0] THR_64_128     = 12'h060;
  localparam logic [11:0] THR_128_256    = 12'h0c0;
  localparam logic [11:0] THR_256_512    = 12'h180;
  localparam logic [11:0] THR_1024_1536  = 12'h500;
  localparam logic [11:0] THR_1536_2048  = 12'h700;

endpackage

// File: hdl/rfi_length_estimate.sv
// preamble length estimate from header code and accumulation count
`timescale 1ns/1ps
module rfi_length_estimate
  import rfi_pkg::*;
(
  input  wire logic [1:0]       hdrRepetition,
  input  wire logic [ACC_W-1:0] accumCount,
  output logic [1:0]            repetitionCode,
  output logic [1:0]            nonstdLengthCode
);

  // standard code passes through; length step refined by the count
  always_comb
  begin
    repetitionCode   = hdrRepetition;
    nonstdLengthCode = NSL_BASE;
    case (hdrRepetition)
      REP_64:
      begin
        if (accumCount < THR_64_128)                         // see (R6)
          nonstdLengthCode = NSL_BASE;                       // see (R7)
        else if (accumCount < THR_128_256)
          nonstdLengthCode = NSL_STEP1;
        else if (accumCount < THR_256_512)
          nonstdLengthCode = NSL_STEP2;
        else
          nonstdLengthCode = NSL_STEP3;
      end
      REP_1024:
      begin
        if (accumCount < THR_1024_1536)                      // see (R6)
          nonstdLengthCode = NSL_BASE;                       // see (R7)
        else if (accumCount < THR_1536_2048)
          nonstdLengthCode = NSL_STEP1;
        else
          nonstdLengthCode = NSL_STEP2;
      end
      default:
      begin
        nonstdLengthCode = NSL_BASE;
      end
    endcase
  end

endmodule

// File: verif/rfi_frame_info_monitor.sv
// checker for the frame information register bank
`timescale 1ns/1ps
module rfi_frame_info_monitor
(
  input wire logic                       ref_clk,
  input wire logic                       arst_n,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [rfi_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [rfi_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic                       headerDetected,
  input wire logic [1:0]                 hdrBitRate,
  input wire logic                       hdrRanging,
  input wire logic [1:0]                 hdrPreambleRepetition,
  input wire logic [rfi_pkg::ACC_W-1:0]  preambleAccumCount,
  input wire logic [1:0]                 receiverPulseRateSetting,
  input wire logic                       headerDetectedFlag
);
  import rfi_pkg::*;
  logic        rdTake, rdInfo_r, pend_r, seen_r, same_r;
  logic [31:0] last_r;
  assign rdTake = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == OFS_INFO;
  function automatic logic [1:0] nsl(logic [1:0] r, logic [11:0] c);
    if (r == 2'h1)
      return c < 12'h060 ? 2'h0 : c < 12'h0c0 ? 2'h1 : c < 12'h180 ? 2'h2 : 2'h3;
    return r == 2'h2 ? (c < 12'h500 ? 2'h0 : c < 12'h700 ? 2'h1 : 2'h2) : 2'h0;
  endfunction
  // remembers whether a header landed since the last info read was taken
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      {rdInfo_r, pend_r, seen_r, same_r} <= 4'h0;
      last_r <= 32'h0;
    end
    else
    begin
      rdInfo_r <= rdTake;
      pend_r <= rdTake ? headerDetected : pend_r | headerDetected;
      if (rdTake)
        {seen_r, same_r} <= {1'b1, seen_r && !pend_r};
      if (wb_ack_o && rdInfo_r)
        last_r <= wb_dat_o;
    end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence sRd;
    headerDetected ##1 rdTake;
  endsequence
  a_flag_set: assert property (headerDetected |=> headerDetectedFlag)
    else $error("flag not set after header");
  a_info_hold: assert property (wb_ack_o && rdInfo_r && same_r |-> wb_dat_o == last_r)
    else $error("info changed without header");
  a_bit_rate: assert property (sRd |=> wb_dat_o[14:13] == $past(hdrBitRate, 2))
    else $error("bit rate field wrong");
  a_ranging_bit: assert property (sRd |=> wb_dat_o[15] == $past(hdrRanging, 2))
    else $error("ranging bit wrong");
  a_pulse_rate: assert property (sRd |=> wb_dat_o[17:16] == $past(receiverPulseRateSetting, 2))
    else $error("pulse rate field wrong");
  a_rep_code: assert property (sRd |=> wb_dat_o[19:18] == $past(hdrPreambleRepetition, 2))
    else $error("repetition field wrong");
  a_accum_count: assert property (sRd |=> wb_dat_o[31:20] == $past(preambleAccumCount, 2))
    else $error("accumulation count wrong");
  a_nonstd_len: assert property (sRd |=> wb_dat_o[12:11] ==
    nsl($past(hdrPreambleRepetition, 2), $past(preambleAccumCount, 2)))
    else $error("length estimate wrong");
  c_hdr_read: cover property (sRd);
  c_hold: cover property (wb_ack_o && rdInfo_r && same_r);
  c_flag: cover property (headerDetected ##1 headerDetectedFlag);
endmodule

bind rfi_frame_info rfi_frame_info_monitor u_mon (.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .headerDetected(headerDetected), .hdrBitRate(hdrBitRate), .hdrRanging(hdrRanging),
  .hdrPreambleRepetition(hdrPreambleRepetition), .preambleAccumCount(preambleAccumCount),
  .receiverPulseRateSetting(receiverPulseRateSetting), .headerDetectedFlag(headerDetectedFlag));

// File: verif/rfi_hdr_source.sv
// header decoder stand-in, one decoded header per call
`timescale 1ns/1ps
module rfi_hdr_source
(
  input  wire logic                      ref_clk,
  output logic                           headerDetected,
  output logic [1:0]                     hdrBitRate,
  output logic                           hdrRanging,
  output logic [1:0]                     hdrPreambleRepetition,
  output logic [rfi_pkg::ACC_W-1:0]      preambleAccumCount
);
  initial
  begin
    headerDetected = 1'b0;
    {hdrBitRate, hdrRanging, hdrPreambleRepetition, preambleAccumCount} = 17'h0;
  end
  // fields go stale right after the pulse
  always @(posedge ref_clk)
    if (headerDetected)
    begin
      headerDetected <= 1'b0;
      {hdrBitRate, hdrRanging, hdrPreambleRepetition, preambleAccumCount} <=
        ~{hdrBitRate, hdrRanging, hdrPreambleRepetition, preambleAccumCount};
    end
  task automatic send(input logic [1:0] br, input logic rx_ranging_flag, input logic [1:0] rep, input logic [11:0] cnt);
    @(posedge ref_clk);
    headerDetected <= 1'b1;
    {hdrBitRate, hdrRanging, hdrPreambleRepetition, preambleAccumCount} <= {br, rx_ranging_flag, rep, cnt};
  endtask
endmodule

// File: verif/rfi_frame_info_tb.sv
// self-checking bench for the frame information register bank
`timescale 1ns/1ps
module rfi_frame_info_tb;
  import rfi_pkg::*;
  logic        ref_clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat, e;
  logic [1:0]  prf = 2'h1, txExt, txRep, hdrBitRate, hdrPreambleRepetition, br, rep;
  logic [11:0] preambleAccumCount, cnt;
  logic        wb_ack_o, headerDetected, hdrRanging, flag, rx_ranging_flag;
  logic [11:0] corner [12] = '{12'h05f, 12'h060, 12'h0bf, 12'h0c0, 12'h17f, 12'h180,
                               12'h4ff, 12'h500, 12'h6ff, 12'h700, 12'h000, 12'hfff};
  int          n_errors = 0, check_count = 0;

  always #5 ref_clk = ~ref_clk;

  rfi_hdr_source u_rfi_hdr_source (.ref_clk(ref_clk), .headerDetected(headerDetected), .hdrBitRate(hdrBitRate),
    .hdrRanging(hdrRanging), .hdrPreambleRepetition(hdrPreambleRepetition), .preambleAccumCount(preambleAccumCount));
  rfi_frame_info u_rfi_frame_info (.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_cyc_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .headerDetected(headerDetected), .hdrBitRate(hdrBitRate), .hdrRanging(hdrRanging),
    .hdrPreambleRepetition(hdrPreambleRepetition), .preambleAccumCount(preambleAccumCount),
    .receiverPulseRateSetting(prf), .headerDetectedFlag(flag), .txLengthExtension(txExt),
    .txPreambleRepetition(txRep));

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    {wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, w, a, d};
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (wb_ack_o !== 1'b1 && i < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      n_errors++;
      wrap_up();
    end
  endtask

  function automatic logic [31:0] expInfo(logic [1:0] b, logic r, logic [1:0] p, logic [1:0] f, logic [11:0] c);
    logic [1:0] n;
    n = 2'h0;
    if (p == 2'h1)
      n = c < 12'h060 ? 2'h0 : c < 12'h0c0 ? 2'h1 : c < 12'h180 ? 2'h2 : 2'h3;
    else if (p == 2'h2)
      n = c < 12'h500 ? 2'h0 : c < 12'h700 ? 2'h1 : 2'h2;
    return {c, p, f, r, b, n, 11'h0};
  endfunction

  initial
  begin
    void'($urandom(76142));
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wb(1'b0, OFS_INFO, 32'h0);
    chk(rdat, 32'h0);
    chk({28'h0, txRep, txExt}, 32'h4);
    $display("test reset done");
    for (int k = 0; k < 24; k++)
    begin
      br = 2'($urandom % 3);
      rx_ranging_flag = 1'($urandom);
      cnt = k % 2 ? 12'($urandom) : corner[k / 2];
      rep = k % 2 ? 2'($urandom) : (cnt < 12'h200 ? REP_64 : REP_1024);
      prf <= $urandom % 2 ? PRF_16M : PRF_64M;
      u_rfi_hdr_source.send(br, rx_ranging_flag, rep, cnt);
      e = expInfo(br, rx_ranging_flag, rep, prf, cnt);
      wb(1'b0, OFS_INFO, 32'h0);
      chk(rdat, e);
      chk({31'h0, flag}, 32'h1);
      wb(1'b1, OFS_INFO, $urandom);
      wb(1'b0, OFS_INFO, 32'h0);
      chk(rdat, e);
      wb(1'b1, OFS_STATUS, 32'h1);
      chk({31'h0, flag}, 32'h0);
      wb(1'b1, OFS_TXCFG, {28'h0, e[19:18], e[12:11]});
      chk({28'h0, txRep, txExt}, {28'h0, e[19:18], e[12:11]});
    end
    $display("test frames done");
    // capture disabled: flag, count and overrun move, info holds
    wb(1'b1, OFS_CTRL, 32'h0);
    u_rfi_hdr_source.send(2'h1, 1'b1, REP_4096, 12'h123);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(rdat, 32'h0019_0001);
    u_rfi_hdr_source.send(2'h2, 1'b0, REP_16, 12'h0ff);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(rdat, 32'h001a_0003);
    wb(1'b0, OFS_INFO, 32'h0);
    chk(rdat, e);
    wb(1'b1, OFS_CTRL, 32'h1);
    wb(1'b1, OFS_STATUS, 32'h3);
    chk({31'h0, flag}, 32'h0);
    $display("test capture off done");
    wb(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h0);
    $display("test unmapped done");
    wrap_up();
  end
endmodule
